/* File: pio_pkg.sv */
// pio_pkg: register map, field positions and bus carriers of the programmable port bank
package pio_pkg;

    // bank geometry
    localparam int NUM_PORTS = 16;
    localparam int PORT_W = 8;

    // register indexes; byte address on the bus is four times the index
    localparam logic [11:0] DATA_IDX [0:15] = '{
        12'h3E0, 12'h3E1, 12'h3E4, 12'h3E5, 12'h3E8, 12'h3E9, 12'h3C0, 12'h3C1,
        12'h3C4, 12'h3C5, 12'h3C8, 12'h3C9, 12'h3CC, 12'h3CD, 12'h3D0, 12'h3D1};
    localparam logic [11:0] DIR_IDX [0:15] = '{
        12'h3E2, 12'h3E3, 12'h3E6, 12'h3E7, 12'h3EA, 12'h3EB, 12'h3C2, 12'h3C3,
        12'h3C6, 12'h3C7, 12'h3CA, 12'h3CB, 12'h3CE, 12'h3CF, 12'h3D2, 12'h3D3};

    // control registers outside the port map
    localparam logic [11:0] ISOLATE_IDX = 12'h400;
    localparam logic [11:0] PROTECT_IDX = 12'h401;
    localparam logic [11:0] MODE_IDX = 12'h402;
    localparam logic [11:0] IRQ_STATUS_IDX = 12'h403;
    localparam logic [11:0] IRQ_MASK_IDX = 12'h404;

    // implemented bits of direction and data registers
    localparam logic [7:0] DIR_IMPL [0:15] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hDF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h7F, 8'hFF};
    localparam logic [7:0] DATA_IMPL [0:15] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h7F, 8'hFF};
    // pins that become external bus lines outside single-chip mode
    localparam logic [7:0] BUS_PIN_MASK [0:15] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // isolation register: bits 0..3 select analog groups, bit 7 the key group
    localparam int ISO_KEY_BIT = 7;
    localparam logic [7:0] ISO_IMPL = 8'h8F;
    localparam int ISO_PORT = 9;
    localparam int ISO_PIN_BASE = 3;
    localparam int KEY_PORT = 10;
    localparam logic [7:0] KEY_PINS = 8'hF0;
    localparam int KEY_LSB = 4;

    // protect register and mode register fields
    localparam int PROTECT_BIT = 2;
    localparam int PROTECTED_PORT = 9;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [7:0] MODE_IMPL = 8'h03;

    // interrupt status bits
    localparam int IRQ_KEY_BIT = 0;
    localparam int IRQ_BLOCK_BIT = 1;
    localparam logic [7:0] IRQ_IMPL = 8'h03;

    // reset values
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // bus carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } pio_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pio_apb_rsp_t;

endpackage : pio_pkg

/* File: pio_port_bank.sv */
// pio_port_bank: byte-wide programmable port bank with analog isolation and key interrupt
//
// Summary of operation
// - isolation bits cut digital inputs from analog pins
// - key isolation cuts key pin reads
// - key isolation holds key request flag at zero
// - direction bit: zero input, one output
// - bus mode ignores direction writes on bus pins
// - unimplemented direction bits ignore writes
// - input port read returns pin level
// - input port write updates latch only
// - output port reads latch, drives latch
// - bus mode ignores data writes, hides level on bus pins
module pio_port_bank #(
    parameter int NUM_PORTS = pio_pkg::NUM_PORTS
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register bus
    input wire pio_pkg::pio_apb_req_t apbReq,
    output pio_pkg::pio_apb_rsp_t apbRsp,
    // package pins
    input wire logic [NUM_PORTS-1:0][7:0] pinIn,
    output logic [NUM_PORTS-1:0][7:0] pinOut,
    output logic [NUM_PORTS-1:0][7:0] pinOe,
    // digital peripheral input paths
    output logic [NUM_PORTS-1:0][7:0] periphIn,
    // interrupt
    output logic irq
);

    // decoded register kind
    typedef enum {PIO_NONE, PIO_DATA, PIO_DIR, PIO_CTRL} pio_kind_t;

    // software state
    logic [NUM_PORTS-1:0][7:0] dirReg;      // direction bits, also pin enables
    logic [NUM_PORTS-1:0][7:0] latchReg;    // port latches, also pin levels
    logic [7:0] isoReg;                     // analog isolation controls
    logic [7:0] protectReg;                 // write protect control
    logic [7:0] modeReg;                    // processor mode, nonzero means bus mode
    logic [7:0] statusReg;                  // sticky interrupt status
    logic [7:0] maskReg;                    // interrupt enables
    logic [3:0] keyPrev;                    // key pin levels one cycle ago
    logic irqReg;
    logic [NUM_PORTS-1:0][7:0] next_dirReg;
    logic [NUM_PORTS-1:0][7:0] next_latchReg;
    logic [7:0] next_isoReg;
    logic [7:0] next_protectReg;
    logic [7:0] next_modeReg;
    logic [7:0] next_statusReg;
    logic [7:0] next_maskReg;
    logic [3:0] next_keyPrev;
    logic next_irqReg;
    // bus response state
    pio_pkg::pio_apb_rsp_t rspReg;
    pio_pkg::pio_apb_rsp_t next_rspReg;
    logic [NUM_PORTS-1:0][7:0] periphReg;
    logic [NUM_PORTS-1:0][7:0] next_periphReg;

    // address decode helpers
    logic [11:0] regIdx;
    logic addrOk;
    logic setupPhase;
    logic accessWrite;
    logic busMode;
    pio_kind_t kind;
    int unsigned portSel;

    // bus pins follow the mode, single-chip mode frees them all
    function automatic logic [7:0] busMask(input int unsigned p, input logic inBus);
        busMask = inBus ? pio_pkg::BUS_PIN_MASK[p] : 8'h00;
    endfunction : busMask

    // pins cut off from digital inputs by the isolation controls
    function automatic logic [7:0] isoMask(input int unsigned p, input logic [7:0] iso);
        logic [7:0] m;
        m = 8'h00;
        if (p == pio_pkg::ISO_PORT) begin
            m = {4'h0, iso[3:0]} << pio_pkg::ISO_PIN_BASE;
        end
        if (p == pio_pkg::KEY_PORT && iso[pio_pkg::ISO_KEY_BIT]) begin
            m = pio_pkg::KEY_PINS;
        end
        isoMask = m;
    endfunction : isoMask

    // read value of one port data register
    function automatic logic [7:0] readData(
        input int unsigned p,
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] pin,
        input logic inBus,
        input logic [7:0] iso
    );
        logic [7:0] v;
        v = (dir & latch) | (~dir & pin);
        v = v & pio_pkg::DATA_IMPL[p] & ~busMask(p, inBus);
        if (p == pio_pkg::KEY_PORT) begin
            v = v & ~isoMask(p, iso);
        end
        readData = v;
    endfunction : readData

    // bus phase decode
    always_comb begin
        regIdx = apbReq.paddr[13:2];
        addrOk = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr[15:14] == 2'h0);
        setupPhase = apbReq.psel && !apbReq.penable;
        // a write takes effect only at the edge that sees pready
        accessWrite = apbReq.psel && apbReq.penable && apbReq.pwrite && rspReg.pready;
        busMode = (modeReg[1:0] != pio_pkg::MODE_SINGLE);
        kind = PIO_NONE;
        portSel = 0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (regIdx == pio_pkg::DATA_IDX[p]) begin
                kind = PIO_DATA;
                portSel = p;
            end
            if (regIdx == pio_pkg::DIR_IDX[p]) begin
                kind = PIO_DIR;
                portSel = p;
            end
        end
        if (regIdx inside {pio_pkg::ISOLATE_IDX, pio_pkg::PROTECT_IDX, pio_pkg::MODE_IDX,
                           pio_pkg::IRQ_STATUS_IDX, pio_pkg::IRQ_MASK_IDX}) begin
            kind = PIO_CTRL;
        end
        if (!addrOk) begin
            kind = PIO_NONE;
        end
    end

    // next state of the software registers and key edge detection
    always_comb begin
        logic [7:0] wd;
        logic [7:0] keep;
        logic keyFall;
        logic blocked;
        wd = apbReq.pwdata[7:0];
        keep = 8'h00;
        blocked = 1'b0;
        keyFall = 1'b0;
        next_dirReg = dirReg;
        next_latchReg = latchReg;
        next_isoReg = isoReg;
        next_protectReg = protectReg;
        next_modeReg = modeReg;
        next_maskReg = maskReg;
        next_keyPrev = pinIn[pio_pkg::KEY_PORT][7:pio_pkg::KEY_LSB];
        next_statusReg = statusReg;
        if (accessWrite) begin
            // the protect enable lasts for one write only
            next_protectReg = 8'h00;
            case (kind)
                PIO_DIR: begin
                    keep = ~pio_pkg::DIR_IMPL[portSel] | busMask(portSel, busMode);
                    if (portSel == pio_pkg::PROTECTED_PORT
                            && !protectReg[pio_pkg::PROTECT_BIT]) begin
                        // unprotected writes to the guarded port are dropped
                        keep = 8'hFF;
                        blocked = 1'b1;
                    end
                    next_dirReg[portSel] = (dirReg[portSel] & keep) | (wd & ~keep);
                    if (busMask(portSel, busMode) != 8'h00) begin
                        blocked = 1'b1;
                    end
                end
                PIO_DATA: begin
                    keep = ~pio_pkg::DATA_IMPL[portSel] | busMask(portSel, busMode);
                    next_latchReg[portSel] = (latchReg[portSel] & keep) | (wd & ~keep);
                    if (busMask(portSel, busMode) != 8'h00) begin
                        blocked = 1'b1;
                    end
                end
                PIO_CTRL: begin
                    if (regIdx == pio_pkg::ISOLATE_IDX) begin
                        next_isoReg = wd & pio_pkg::ISO_IMPL;
                    end
                    if (regIdx == pio_pkg::PROTECT_IDX) begin
                        next_protectReg = wd & (8'h01 << pio_pkg::PROTECT_BIT);
                    end
                    if (regIdx == pio_pkg::MODE_IDX) begin
                        next_modeReg = wd & pio_pkg::MODE_IMPL;
                    end
                    if (regIdx == pio_pkg::IRQ_MASK_IDX) begin
                        next_maskReg = wd & pio_pkg::IRQ_IMPL;
                    end
                    if (regIdx == pio_pkg::IRQ_STATUS_IDX) begin
                        // write one to clear
                        next_statusReg = statusReg & ~wd;
                    end
                end
                default: begin
                    next_protectReg = 8'h00;
                end
            endcase
        end
        // falling edge on any key pin; pins are active low
        keyFall = |(keyPrev & ~pinIn[pio_pkg::KEY_PORT][7:pio_pkg::KEY_LSB]);
        // new events win over a clear in the same cycle
        if (keyFall) begin
            next_statusReg[pio_pkg::IRQ_KEY_BIT] = 1'b1;
        end
        if (blocked) begin
            next_statusReg[pio_pkg::IRQ_BLOCK_BIT] = 1'b1;
        end
        if (isoReg[pio_pkg::ISO_KEY_BIT]) begin
            next_statusReg[pio_pkg::IRQ_KEY_BIT] = 1'b0;
        end
        next_irqReg = |(next_statusReg & next_maskReg);
    end

    // software registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dirReg <= {NUM_PORTS{pio_pkg::DIR_RESET}};
            latchReg <= {NUM_PORTS{pio_pkg::DATA_RESET}};
            isoReg <= pio_pkg::CTRL_RESET;
            protectReg <= pio_pkg::CTRL_RESET;
            modeReg <= pio_pkg::CTRL_RESET;
            statusReg <= pio_pkg::CTRL_RESET;
            maskReg <= pio_pkg::CTRL_RESET;
            keyPrev <= 4'hF;
            irqReg <= 1'b0;
        end else begin
            dirReg <= next_dirReg;
            latchReg <= next_latchReg;
            isoReg <= next_isoReg;
            protectReg <= next_protectReg;
            modeReg <= next_modeReg;
            statusReg <= next_statusReg;
            maskReg <= next_maskReg;
            keyPrev <= next_keyPrev;
            irqReg <= next_irqReg;
        end
    end

    // read mux and response; answer is prepared in setup so pready rises in access
    always_comb begin
        next_rspReg = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            // isolated pins give zero to peripherals
            next_periphReg[p] = pinIn[p] & ~isoMask(p, isoReg);
        end
        if (setupPhase) begin
            next_rspReg.pready = 1'b1;
            next_rspReg.pslverr = (kind == PIO_NONE);
            case (kind)
                PIO_DATA: begin
                    next_rspReg.prdata[7:0] = readData(portSel, dirReg[portSel],
                        latchReg[portSel], pinIn[portSel], busMode, isoReg);
                end
                PIO_DIR: begin
                    next_rspReg.prdata[7:0] = dirReg[portSel] & pio_pkg::DIR_IMPL[portSel];
                end
                PIO_CTRL: begin
                    case (regIdx)
                        pio_pkg::ISOLATE_IDX: next_rspReg.prdata[7:0] = isoReg;
                        pio_pkg::PROTECT_IDX: next_rspReg.prdata[7:0] = protectReg;
                        pio_pkg::MODE_IDX: next_rspReg.prdata[7:0] = modeReg;
                        pio_pkg::IRQ_STATUS_IDX: next_rspReg.prdata[7:0] = statusReg;
                        default: next_rspReg.prdata[7:0] = maskReg;
                    endcase
                end
                default: begin
                    next_rspReg.prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // bus response and peripheral input registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rspReg <= '0;
            periphReg <= '0;
        end else begin
            rspReg <= next_rspReg;
            periphReg <= next_periphReg;
        end
    end

    // outputs straight from flops
    // output pins drive latch level
    assign pinOut = latchReg;
    assign pinOe = dirReg;
    assign periphIn = periphReg;
    assign apbRsp = rspReg;
    assign irq = irqReg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence setupRead(logic [11:0] idx);
        setupPhase && !apbReq.pwrite && addrOk && regIdx == idx;
    endsequence

    sequence doneWrite(logic [11:0] idx);
        accessWrite && addrOk && regIdx == idx;
    endsequence

    bus_answer_a: assert property (setupPhase |=> rspReg.pready ##1 !rspReg.pready) // APB
        else $error("pready not a single access cycle");
    key_flag_iso_a: assert property (isoReg[7] |=> !statusReg[0])
        else $error("key flag set while isolated");
    key_read_iso_a: assert property (
        setupRead(pio_pkg::DATA_IDX[10]) ##0 isoReg[7]
        |=> rspReg.prdata[7:4] == 4'h0)
        else $error("isolated key pins read nonzero");
    dir_write_a: assert property (
        doneWrite(pio_pkg::DIR_IDX[1]) ##0 !busMode
        |=> pinOe[1] == $past(apbReq.pwdata[7:0]))
        else $error("direction write not applied");
    dir_bus_a: assert property (
        doneWrite(pio_pkg::DIR_IDX[0]) ##0 busMode
        |=> $stable(pinOe[0]) ##1 statusReg[1])
        else $error("bus pin direction changed");
    latch_drive_a: assert property (
        doneWrite(pio_pkg::DATA_IDX[7]) ##0 dirReg[7] == 8'hFF
        |=> pinOut[7] == $past(apbReq.pwdata[7:0]) && pinOe[7] == 8'hFF)
        else $error("output latch not driven");
    input_write_a: assert property (
        doneWrite(pio_pkg::DATA_IDX[6]) ##0 dirReg[6] == 8'h00
        |=> pinOe[6] == 8'h00)
        else $error("input pin became driven");
    pin_read_a: assert property (
        setupRead(pio_pkg::DATA_IDX[6]) ##0 dirReg[6] == 8'h00
        |=> rspReg.prdata[7:0] == $past(pinIn[6]))
        else $error("input read not pin level");
    unimpl_dir_a: assert property (
        setupRead(pio_pkg::DIR_IDX[11])
        |=> rspReg.prdata[7:5] == 3'h0)
        else $error("unimplemented direction bits nonzero");
    bus_read_a: assert property (
        setupRead(pio_pkg::DATA_IDX[0]) ##0 busMode
        |=> rspReg.prdata[7:0] == 8'h00)
        else $error("bus pin level visible");
    analog_iso_a: assert property (isoReg[0] |=> periphIn[9][3] == 1'b0)
        else $error("isolated pin reaches peripheral");
    analog_top_a: assert property (isoReg[3] |=> periphIn[9][6] == 1'b0)
        else $error("isolated top analog pin reaches peripheral");
    protect_guard_a: assert property ( // protect
        doneWrite(pio_pkg::DIR_IDX[9]) ##0 !protectReg[pio_pkg::PROTECT_BIT]
        |=> $stable(pinOe[9]) && statusReg[1])
        else $error("unprotected direction write applied");
    key_edge_a: assert property ( // interrupt
        !isoReg[7] && (keyPrev & ~pinIn[10][7:4]) != 4'h0
        |=> statusReg[0])
        else $error("key edge missed by status flag");
    unmapped_err_a: assert property (
        setupPhase && kind == PIO_NONE
        |=> rspReg.pslverr && rspReg.prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    irq_level_a: assert property (irq == |(statusReg & maskReg)) // interrupt
        else $error("irq disagrees with status and mask");

endmodule : pio_port_bank

/* File: pio_pin_model.sv */
// pio_pin_model: board-side model of the package pins facing the port bank
module pio_pin_model (
    // design side of each pin
    input wire logic [15:0][7:0] pinOut,
    input wire logic [15:0][7:0] pinOe,
    // level that the board applies where the bank does not drive
    input wire logic [15:0][7:0] extLevel,
    // resolved pin levels fed back to the bank
    output logic [15:0][7:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;

    // a driven pin shows the latch; an undriven pin shows the board level,
    // which the bench always sets, so no pin is ever left floating
    always_comb begin
        pinLevel = (pinOut & pinOe) | (extLevel & ~pinOe);
    end

endmodule : pio_pin_model

/* File: test_pio_port_bank.sv */
// test_pio_port_bank: self-checking bench for the port bank over APB
module test_pio_port_bank;
    timeunit 1ns;
    timeprecision 1ps;

    // one register case: index, write value, expected readback and error
    typedef struct {
        logic [11:0] idx;
        logic [7:0] wd;
        logic [31:0] exp;
        logic err;
    } pio_row_t;

    logic clk;
    logic arst_n;
    pio_pkg::pio_apb_req_t apbReq;
    pio_pkg::pio_apb_rsp_t apbRsp;
    // pin levels on both sides of the model
    logic [15:0][7:0] extLevel;
    logic [15:0][7:0] pinLevel;
    logic [15:0][7:0] pinOut;
    logic [15:0][7:0] pinOe;
    logic [15:0][7:0] periphIn;
    logic irq;
    // last read answer
    logic [31:0] rd;
    logic er;
    int failCount = 0;
    int nTests = 0;
    pio_row_t rows [17];

    pio_port_bank u_dut (
        .clk(clk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
        .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe), .periphIn(periphIn), .irq(irq)
    );

    pio_pin_model u_pins (
        .pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinLevel(pinLevel)
    );

    // free-running bus clock, 40 ns
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // compare and count; four-state equality so unknowns never match
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one APB transfer; the request stands until pready is seen high
    task apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        apbReq <= '{psel:1'h1, penable:1'h0, pwrite:wr, paddr:{2'h0, idx, 2'h0},
                    pwdata:{24'h0, wd}};
        @(posedge clk);
        apbReq.penable <= 1'h1;
        // flops still show their pre-edge value here, as the slave sees them
        do begin
            @(posedge clk);
            n++;
        end while (apbRsp.pready !== 1'h1 && n < 50);
        if (apbRsp.pready !== 1'h1) failCount++;
        // answer is taken at the edge that samples pready, then released
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq <= '0;
    endtask : apb

    // read a register and compare it
    task rdc(input string name, input logic [11:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00);
        check(name, rd, {24'h0, exp});
    endtask : rdc

    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // print counts and the verdict, then stop
    task completeRun();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : completeRun

    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        completeRun();
    end

    initial begin
        // key pins idle high since they are active low
        arst_n = 1'h0;
        apbReq = '0;
        extLevel = '0;
        extLevel[9] = 8'hFF;
        extLevel[10] = 8'hF5;
        rows = '{
            '{pio_pkg::DIR_IDX[1], 8'hA5, 32'hA5, 1'h0},
            '{pio_pkg::DIR_IDX[8], 8'hFF, 32'hDF, 1'h0},
            '{pio_pkg::DIR_IDX[11], 8'hFF, 32'h1F, 1'h0},
            '{pio_pkg::DIR_IDX[12], 8'hFF, 32'hFF, 1'h0},
            '{pio_pkg::DIR_IDX[13], 8'hFF, 32'hFF, 1'h0},
            '{pio_pkg::DIR_IDX[14], 8'hFF, 32'h7F, 1'h0},
            '{pio_pkg::DIR_IDX[15], 8'hFF, 32'hFF, 1'h0},
            '{pio_pkg::ISOLATE_IDX, 8'hFF, 32'h8F, 1'h0},
            '{pio_pkg::ISOLATE_IDX, 8'h00, 32'h00, 1'h0},
            '{pio_pkg::DIR_IDX[7], 8'hFF, 32'hFF, 1'h0},
            '{pio_pkg::DATA_IDX[7], 8'h96, 32'h96, 1'h0},
            '{pio_pkg::PROTECT_IDX, 8'h04, 32'h04, 1'h0},
            '{pio_pkg::MODE_IDX, 8'hFF, 32'h03, 1'h0},
            '{pio_pkg::MODE_IDX, 8'h00, 32'h00, 1'h0},
            '{pio_pkg::IRQ_MASK_IDX, 8'hFF, 32'h03, 1'h0},
            '{pio_pkg::IRQ_MASK_IDX, 8'h00, 32'h00, 1'h0},
            '{12'h3D4, 8'hFF, 32'h00, 1'h1}};
        idle(5);
        arst_n <= 1'h1;
        // directions come out of reset as inputs
        for (int p = 0; p < 16; p++) rdc("direction reset", pio_pkg::DIR_IDX[p], 8'h00);
        check("reset outputs", {31'h0, (pinOe === '0) && (pinOut === '0)}, 32'h1);
        foreach (rows[i]) begin
            apb(1'h1, rows[i].idx, rows[i].wd);
            apb(1'h0, rows[i].idx, 8'h00);
            check("row read", rd, rows[i].exp);
            check("row error", {31'h0, er}, {31'h0, rows[i].err});
        end
        // input reads pin, write only latches
        extLevel[6] <= 8'h3C;
        apb(1'h1, pio_pkg::DATA_IDX[6], 8'h5A);
        rdc("input read", pio_pkg::DATA_IDX[6], 8'h3C);
        check("input not driven", {24'h0, pinOe[6]}, 32'h0);
        // output bits read and drive the latch
        apb(1'h1, pio_pkg::DIR_IDX[6], 8'hF0);
        idle(2);
        rdc("mixed read", pio_pkg::DATA_IDX[6], 8'h5C);
        apb(1'h1, pio_pkg::DATA_IDX[6], 8'hA5);
        idle(2);
        check("output level", {24'h0, pinOut[6] & pinOe[6]}, 32'hA0);
        rdc("output read", pio_pkg::DATA_IDX[6], 8'hAC);
        idle(2);
        check("periph open", {24'h0, periphIn[9]}, 32'hFF);
        apb(1'h1, pio_pkg::ISOLATE_IDX, 8'h0F);
        idle(3);
        check("periph isolated", {24'h0, periphIn[9]}, 32'h87);
        apb(1'h1, pio_pkg::ISOLATE_IDX, 8'h00);
        // key event while masked, then unmasked, then cleared
        extLevel[10] <= 8'hE5;
        idle(4);
        check("masked irq", {31'h0, irq}, 32'h0);
        rdc("key status", pio_pkg::IRQ_STATUS_IDX, 8'h01);
        apb(1'h1, pio_pkg::IRQ_MASK_IDX, 8'h01);
        idle(2);
        check("unmasked irq", {31'h0, irq}, 32'h1);
        apb(1'h1, pio_pkg::IRQ_STATUS_IDX, 8'h01);
        idle(2);
        check("cleared irq", {31'h0, irq}, 32'h0);
        // key isolation hides reads and holds the flag
        extLevel[10] <= 8'hF5;
        apb(1'h1, pio_pkg::ISOLATE_IDX, 8'h80);
        rdc("key isolated read", pio_pkg::DATA_IDX[10], 8'h05);
        extLevel[10] <= 8'h05;
        idle(4);
        check("isolated irq", {31'h0, irq}, 32'h0);
        rdc("isolated status", pio_pkg::IRQ_STATUS_IDX, 8'h00);
        extLevel[10] <= 8'hF5;
        idle(3);
        apb(1'h1, pio_pkg::ISOLATE_IDX, 8'h00);
        // protected direction needs the enable just before
        apb(1'h1, pio_pkg::DIR_IDX[9], 8'h33);
        rdc("unprotected write", pio_pkg::DIR_IDX[9], 8'h00);
        apb(1'h0, pio_pkg::IRQ_STATUS_IDX, 8'h00);
        check("blocked flag", {31'h0, rd[1]}, 32'h1);
        apb(1'h1, pio_pkg::PROTECT_IDX, 8'h04);
        apb(1'h1, pio_pkg::DIR_IDX[9], 8'h33);
        apb(1'h1, pio_pkg::DIR_IDX[9], 8'h00);
        rdc("protected write", pio_pkg::DIR_IDX[9], 8'h33);
        apb(1'h1, pio_pkg::IRQ_STATUS_IDX, 8'h03);
        // bus mode freezes bus pin registers
        extLevel[0] <= 8'h3C;
        apb(1'h1, pio_pkg::MODE_IDX, 8'h01);
        apb(1'h1, pio_pkg::DIR_IDX[0], 8'hFF);
        rdc("bus pin direction", pio_pkg::DIR_IDX[0], 8'h00);
        apb(1'h1, pio_pkg::DATA_IDX[0], 8'hAA);
        idle(2);
        check("bus pin latch", {24'h0, pinOut[0]}, 32'h0);
        rdc("bus pin read", pio_pkg::DATA_IDX[0], 8'h00);
        apb(1'h1, pio_pkg::MODE_IDX, 8'h00);
        rdc("single chip read", pio_pkg::DATA_IDX[0], 8'h3C);
        // second reset in mid-run clears every direction
        @(posedge clk);
        arst_n <= 1'h0;
        #1;
        check("reset enables", {31'h0, pinOe === '0}, 32'h1);
        idle(5);
        arst_n <= 1'h1;
        rdc("direction rereset", pio_pkg::DIR_IDX[1], 8'h00);
        completeRun();
    end

endmodule : test_pio_port_bank
